// >>> design/aar_pkg.sv
package aar_pkg;
  // Register indices on the management port
  localparam logic [4:0] AAR_IDX_ADV = 5'h04;
  localparam logic [4:0] AAR_IDX_LPA = 5'h05;
  localparam logic [4:0] AAR_IDX_EXP = 5'h06;

  // Local advertisement field positions
  localparam int ADV_NEXT_PAGE = 15;
  localparam int ADV_REMOTE_FAULT = 13;
  localparam int ADV_EXT_NEXT_PAGE = 12;
  localparam int ADV_ASYM_PAUSE = 11;
  localparam int ADV_SYM_PAUSE = 10;
  localparam int ADV_T4 = 9;
  localparam int ADV_TX_FULL = 8;
  localparam int ADV_TX_HALF = 7;
  localparam int ADV_T10_FULL = 6;
  localparam int ADV_T10_HALF = 5;
  localparam int SEL_MSB = 4;

  // Writable bits of the advertisement word; bit 14 is reserved
  localparam logic [15:0] ADV_WRITE_MASK = 16'hBFFF;
  localparam logic [15:0] ADV_RESET = 16'h0C01;
  localparam logic [4:0] SEL_IEEE8023 = 5'h01;

  // Strap bit order: full100, half100, full10, half10
  localparam int STRAP_TX_FULL = 3;
  localparam int STRAP_TX_HALF = 2;
  localparam int STRAP_T10_FULL = 1;
  localparam int STRAP_T10_HALF = 0;

  // Partner ability field positions
  localparam int LPA_NEXT_PAGE = 15;
  localparam int LPA_ACK = 14;
  localparam logic [15:0] LPA_RESET = 16'h0000;

  // Expansion field positions
  localparam int EXP_NP_LOC_ABLE = 6;
  localparam int EXP_NP_LOC = 5;
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_LP_NP_ABLE = 3;
  localparam int EXP_NP_ABLE = 2;
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_LP_AN_ABLE = 0;

  // Events reported by the negotiation engine
  typedef struct packed {
    logic pageValid;
    logic basePage;
    logic [15:0] word;
    logic parallelFault;
    logic partnerAnAble;
  } aar_link_type;

  // One management access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] index;
    logic [15:0] data;
  } aar_mgmt_type;
endpackage : aar_pkg

// >>> design/aar_regs.sv
// Notes on behaviour
// [RQ1] Advertisement bit 6 writable; set advertises 10BASE-T full duplex.
// [RQ2] Advertisement bit 5 writable; set advertises 10BASE-T half duplex.
// [RQ3] Selector bits 4:0 writable, reset 00001 meaning IEEE 802.3.
// [RQ4] 10/100 duplex advertisement defaults come from four strap inputs at reset.
// [RQ5] Partner register read-only; bit15 next page, bit14 word received; reset 0.
// [RQ6] Partner bit13 remote fault, bit12 extended next page; read-only, reset 0.
// [RQ7] Partner bit11 asymmetric pause, bit10 symmetric pause; read-only, reset 0.
// [RQ8] Partner bits 9..5: T4, 100 full, 100 half, 10 full, 10 half.
// [RQ9] Partner selector bits 4:0 read-only, reset zero, holds partner message type.
// [RQ10] Expansion bit 6 always reads 1.
// [RQ11] Expansion bit 5 always reads 1: next pages go to index 8.
// [RQ12] Expansion bit 4 latches high on parallel detection fault; reset 0.
// [RQ13] Expansion bit 3 shows partner next page ability; reset 0.
// [RQ14] Expansion bit 2 always reads 1: local next page support.
// [RQ15] Expansion bit 1 latches high on every received page; reset 0.
// [RQ16] Expansion bit 0 shows partner negotiation ability; reset 0.
// [RQ17] Latched flags hold until expansion register read; new event beats clear.
// [RQ18] Partner register loads from each received base page; writes ignored.
// [RQ19] Advertisement index 4 read/write; pause bits 11,10 default to 1.
module aar_regs
  import aar_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] modeStrap,
  input wire aar_mgmt_type mgmt,
  input wire aar_link_type link,
  output logic [15:0] rdData,
  output logic rdValid,
  output logic [15:0] advWord
);

  logic [15:0] adv_reg;
  logic strapDone_reg;
  logic [15:0] lpa_reg;
  logic pdFault_reg;
  logic pageRx_reg;
  logic anAble_reg;
  logic [15:0] expView;
  logic [15:0] rdMux;
  logic expRead;

  assign expRead = mgmt.rd && (mgmt.index == AAR_IDX_EXP);

  // Straps are caught on the first edge after release, never under reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strapDone_reg <= 1'b0;
    end else begin
      strapDone_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      adv_reg <= ADV_RESET; // RQ3 RQ19
    end else if (!strapDone_reg) begin
      adv_reg[ADV_TX_FULL] <= modeStrap[STRAP_TX_FULL]; // RQ4
      adv_reg[ADV_TX_HALF] <= modeStrap[STRAP_TX_HALF]; // RQ4
      adv_reg[ADV_T10_FULL] <= modeStrap[STRAP_T10_FULL]; // RQ4
      adv_reg[ADV_T10_HALF] <= modeStrap[STRAP_T10_HALF]; // RQ4
    end else if (mgmt.wr && mgmt.index == AAR_IDX_ADV) begin
      adv_reg <= mgmt.data & ADV_WRITE_MASK; // RQ1 RQ2 RQ3 RQ19
    end
  end

  // The negotiation engine sends exactly what is stored
  assign advWord = adv_reg; // RQ1 RQ2

  // Management writes never reach this register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lpa_reg <= LPA_RESET; // RQ5 RQ6 RQ7 RQ8 RQ9
    end else if (link.pageValid && link.basePage) begin
      lpa_reg <= link.word; // RQ18 RQ6 RQ7 RQ8 RQ9
      lpa_reg[LPA_ACK] <= 1'b1; // RQ5
    end
  end

  // Set is listed last so an event in the read cycle survives
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pdFault_reg <= 1'b0;
      pageRx_reg <= 1'b0;
    end else begin
      if (expRead) begin
        pdFault_reg <= 1'b0; // RQ17
        pageRx_reg <= 1'b0; // RQ17
      end
      if (link.parallelFault) begin
        pdFault_reg <= 1'b1; // RQ12
      end
      if (link.pageValid) begin
        pageRx_reg <= 1'b1; // RQ15
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      anAble_reg <= 1'b0;
    end else begin
      anAble_reg <= link.partnerAnAble; // RQ16
    end
  end

  always_comb begin
    expView = 16'h0000;
    expView[EXP_NP_LOC_ABLE] = 1'b1; // RQ10
    expView[EXP_NP_LOC] = 1'b1; // RQ11
    expView[EXP_PD_FAULT] = pdFault_reg;
    expView[EXP_LP_NP_ABLE] = lpa_reg[LPA_NEXT_PAGE]; // RQ13
    expView[EXP_NP_ABLE] = 1'b1; // RQ14
    expView[EXP_PAGE_RX] = pageRx_reg;
    expView[EXP_LP_AN_ABLE] = anAble_reg;
  end

  always_comb begin
    case (mgmt.index)
      AAR_IDX_ADV: rdMux = adv_reg;
      AAR_IDX_LPA: rdMux = lpa_reg;
      AAR_IDX_EXP: rdMux = expView;
      default: rdMux = 16'h0000;
    endcase
  end

  // Read data shows the state before any clear of the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData <= 16'h0000;
      rdValid <= 1'b0;
    end else begin
      rdValid <= mgmt.rd;
      if (mgmt.rd) begin
        rdData <= rdMux;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  adv_write_a: assert property ( // RQ1
    strapDone_reg && mgmt.wr && mgmt.index == AAR_IDX_ADV
    |=> adv_reg == ($past(mgmt.data) & ADV_WRITE_MASK))
    else $error("advertisement write not stored");

  // The attempt at the releasing edge still sees reset high and must not start
  strap_load_a: assert property ( // RQ4
    !rst && !strapDone_reg
    |=> adv_reg[ADV_T10_FULL] == $past(modeStrap[STRAP_T10_FULL])
      && adv_reg[ADV_T10_HALF] == $past(modeStrap[STRAP_T10_HALF]))
    else $error("strap defaults not loaded");

  lpa_noWrite_a: assert property ( // RQ18
    !link.pageValid |=> $stable(lpa_reg))
    else $error("partner register changed without a page");

  lpa_update_a: assert property ( // RQ5
    link.pageValid && link.basePage
    |=> lpa_reg[LPA_ACK] && lpa_reg[13:0] == $past(link.word[13:0]))
    else $error("partner register not updated");

  exp_const_a: assert property ( // RQ10
    expView[15:7] == 9'h000 && expView[EXP_NP_LOC_ABLE] && expView[EXP_NP_LOC]
      && expView[EXP_NP_ABLE])
    else $error("expansion constants wrong");

  fault_latch_a: assert property ( // RQ12
    link.parallelFault |=> pdFault_reg [*1] ##0 expView[EXP_PD_FAULT])
    else $error("parallel fault not latched");

  page_hold_a: assert property ( // RQ17
    pageRx_reg && !expRead |=> pageRx_reg)
    else $error("page flag dropped without read");

  page_clear_a: assert property ( // RQ15
    expRead && !link.pageValid |=> !pageRx_reg)
    else $error("page flag not cleared by read");

  read_data_a: assert property ( // RQ13
    mgmt.rd && mgmt.index == AAR_IDX_EXP
    |=> rdValid && rdData[EXP_LP_NP_ABLE] == $past(lpa_reg[LPA_NEXT_PAGE])
      && rdData[EXP_PAGE_RX] == $past(pageRx_reg))
    else $error("expansion read data wrong");

  adv_full10_a: assert property ( // RQ1
    strapDone_reg && mgmt.wr && mgmt.index == AAR_IDX_ADV
    |=> advWord[ADV_T10_FULL] == $past(mgmt.data[ADV_T10_FULL]))
    else $error("10 full advertisement bit not written");

  adv_half10_a: assert property ( // RQ2
    strapDone_reg && mgmt.wr && mgmt.index == AAR_IDX_ADV
    |=> advWord[ADV_T10_HALF] == $past(mgmt.data[ADV_T10_HALF]))
    else $error("10 half advertisement bit not written");

  sel_write_a: assert property ( // RQ3
    strapDone_reg && mgmt.wr && mgmt.index == AAR_IDX_ADV
    |=> advWord[SEL_MSB:0] == $past(mgmt.data[SEL_MSB:0]))
    else $error("selector field not written");

  sel_reset_a: assert property ( // RQ3
    !rst && !strapDone_reg |=> adv_reg[SEL_MSB:0] == SEL_IEEE8023)
    else $error("selector reset value wrong");

  adv_hold_a: assert property ( // RQ1
    strapDone_reg && !(mgmt.wr && mgmt.index == AAR_IDX_ADV) |=> $stable(adv_reg))
    else $error("advertisement changed without a write");

  adv_resv_a: assert property ( // RQ19
    adv_reg[14] == 1'b0)
    else $error("reserved advertisement bit set");

  pause_reset_a: assert property ( // RQ19
    !rst && !strapDone_reg |=> adv_reg[ADV_ASYM_PAUSE] && adv_reg[ADV_SYM_PAUSE])
    else $error("pause defaults wrong");

  strap_fast_a: assert property ( // RQ4
    !rst && !strapDone_reg
    |=> adv_reg[ADV_TX_FULL] == $past(modeStrap[STRAP_TX_FULL])
      && adv_reg[ADV_TX_HALF] == $past(modeStrap[STRAP_TX_HALF]))
    else $error("100 strap defaults not loaded");

  strap_once_a: assert property ( // RQ4
    strapDone_reg |=> strapDone_reg)
    else $error("strap load repeated");

  lpa_np_a: assert property ( // RQ5
    link.pageValid && link.basePage
    |=> lpa_reg[LPA_NEXT_PAGE] == $past(link.word[LPA_NEXT_PAGE]))
    else $error("partner next page bit wrong");

  lpa_fault_a: assert property ( // RQ6
    link.pageValid && link.basePage |=> lpa_reg[13:12] == $past(link.word[13:12]))
    else $error("partner fault bits wrong");

  lpa_pause_a: assert property ( // RQ7
    link.pageValid && link.basePage |=> lpa_reg[11:10] == $past(link.word[11:10]))
    else $error("partner pause bits wrong");

  lpa_tech_a: assert property ( // RQ8
    link.pageValid && link.basePage |=> lpa_reg[9:5] == $past(link.word[9:5]))
    else $error("partner technology bits wrong");

  lpa_sel_a: assert property ( // RQ9
    link.pageValid && link.basePage |=> lpa_reg[4:0] == $past(link.word[4:0]))
    else $error("partner selector wrong");

  lpa_nextpg_a: assert property ( // RQ18
    link.pageValid && !link.basePage |=> $stable(lpa_reg))
    else $error("next page overwrote partner register");

  lpa_read_a: assert property ( // RQ5
    mgmt.rd && mgmt.index == AAR_IDX_LPA |=> rdData == $past(lpa_reg))
    else $error("partner read data wrong");

  adv_read_a: assert property ( // RQ19
    mgmt.rd && mgmt.index == AAR_IDX_ADV |=> rdData == $past(adv_reg))
    else $error("advertisement read data wrong");

  exp_loc_a: assert property ( // RQ11
    mgmt.rd && mgmt.index == AAR_IDX_EXP |=> rdData[6:5] == 2'b11)
    else $error("next page location bits wrong");

  exp_npable_a: assert property ( // RQ14
    mgmt.rd && mgmt.index == AAR_IDX_EXP |=> rdData[EXP_NP_ABLE])
    else $error("local next page bit wrong");

  page_set_a: assert property ( // RQ15
    link.pageValid |=> pageRx_reg)
    else $error("page flag not set");

  set_wins_a: assert property ( // RQ17
    expRead && link.pageValid |=> pageRx_reg)
    else $error("page event lost to read clear");

  fault_hold_a: assert property ( // RQ17
    pdFault_reg && !expRead |=> pdFault_reg)
    else $error("fault flag dropped without read");

  fault_clear_a: assert property ( // RQ12
    expRead && !link.parallelFault |=> !pdFault_reg)
    else $error("fault flag not cleared by read");

  anable_a: assert property ( // RQ16
    strapDone_reg |=> anAble_reg == $past(link.partnerAnAble))
    else $error("partner able bit not tracked");

  rd_pulse_a: assert property ( // RQ13
    !mgmt.rd |=> !rdValid)
    else $error("read valid without a read");

  rd_unmapped_a: assert property ( // RQ18
    mgmt.rd && mgmt.index != AAR_IDX_ADV && mgmt.index != AAR_IDX_LPA
      && mgmt.index != AAR_IDX_EXP
    |=> rdData == 16'h0000)
    else $error("unmapped index read nonzero");

endmodule : aar_regs

// >>> bench/aar_link_model.sv
module aar_link_model
  import aar_pkg::*;
(
  input wire logic core_clk,
  input wire logic [1:0] cmd,
  input wire logic able,
  input wire logic [15:0] w,
  output aar_link_type link
);
  timeunit 1ns;
  timeprecision 1ns;
  // Word is inverted outside a page so a stale value never looks valid
  always_ff @(posedge core_clk) begin
    link.pageValid <= cmd[0];
    link.basePage <= cmd == 2'h1;
    link.word <= cmd[0] ? w : ~w;
    link.parallelFault <= cmd == 2'h2;
    link.partnerAnAble <= able;
  end
endmodule : aar_link_model

// >>> bench/tb_top.sv
module tb_top
  import aar_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] modeStrap = 4'h0;
  aar_mgmt_type mgmt = '0;
  aar_link_type link;
  logic [15:0] rdData;
  logic [15:0] advWord;
  logic rdValid;
  logic [1:0] cmd = 2'h0;
  logic able = 1'b0;
  logic [15:0] w = 16'h0000;
  logic [31:0] seed = 32'h00001C32;
  logic [15:0] expQ[$];
  logic [15:0] tv[4] = '{16'h0040, 16'h0020, 16'hFFFF, 16'h0000};
  logic [15:0] v;
  logic [15:0] f;
  int error_cnt = 0;
  int compares = 0;

  aar_regs i_dut (.core_clk(core_clk), .rst(rst), .modeStrap(modeStrap), .mgmt(mgmt),
    .link(link), .rdData(rdData), .rdValid(rdValid), .advWord(advWord));
  aar_link_model i_link (.core_clk(core_clk), .cmd(cmd), .able(able), .w(w), .link(link));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : xs

  task automatic ck(input string n, input logic [15:0] x, input logic [15:0] y);
    compares++;
    if (y !== x) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, x, y);
    end
  endtask : ck

  // Reads carry their expected word in d; writes carry the data
  task automatic acc(input logic r, input logic [4:0] i, input logic [15:0] d);
    @(posedge core_clk);
    mgmt <= '{rd: r, wr: !r, index: i, data: d};
    if (r) expQ.push_back(d);
    @(posedge core_clk);
    mgmt <= '0;
  endtask : acc

  task automatic ev(input logic [1:0] c, input logic [15:0] x);
    @(posedge core_clk);
    cmd <= c;
    w <= x;
    @(posedge core_clk);
    cmd <= 2'h0;
    @(posedge core_clk);
  endtask : ev

  task automatic results();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  always @(posedge core_clk) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() != 0) ck("rdData", expQ.pop_front(), rdData);
      else ck("rdValid", 16'h0000, 16'h0001);
    end
  end

  initial begin
    v = xs();
    modeStrap = v[3:0];
    able = 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    acc(1, AAR_IDX_ADV, 16'h0C01 | {7'h00, modeStrap, 5'h00});
    acc(1, AAR_IDX_LPA, 16'h0000);
    acc(1, AAR_IDX_EXP, 16'h0065);
    for (int k = 0; k < 6; k++) begin
      v = (k < 4) ? tv[k] : xs();
      acc(0, AAR_IDX_ADV, v);
      #1 ck("advWord", v & 16'hBFFF, advWord);
      acc(1, AAR_IDX_ADV, v & 16'hBFFF);
    end
    acc(0, AAR_IDX_LPA, 16'hFFFF);
    acc(0, AAR_IDX_EXP, 16'h0000);
    acc(1, AAR_IDX_LPA, 16'h0000);
    acc(1, AAR_IDX_EXP, 16'h0065);
    acc(1, 5'h09, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      v = xs();
      v[15] = k[0];
      f = {12'h000, v[15], 3'h0};
      ev(2'h1, v);
      acc(1, AAR_IDX_LPA, v | 16'h4000);
      acc(1, AAR_IDX_EXP, 16'h0067 | f);
      acc(1, AAR_IDX_EXP, 16'h0065 | f);
    end
    ev(2'h3, ~v);
    acc(1, AAR_IDX_LPA, v | 16'h4000);
    acc(1, AAR_IDX_EXP, 16'h0067 | f);
    ev(2'h2, 16'h0000);
    acc(1, AAR_IDX_EXP, 16'h0075 | f);
    acc(1, AAR_IDX_EXP, 16'h0065 | f);
    @(posedge core_clk);
    cmd <= 2'h3;
    w <= v;
    @(posedge core_clk);
    cmd <= 2'h0;
    mgmt <= '{rd: 1'b1, wr: 1'b0, index: AAR_IDX_EXP, data: 16'h0000};
    expQ.push_back(16'h0065 | f);
    @(posedge core_clk);
    mgmt <= '0;
    acc(1, AAR_IDX_EXP, 16'h0067 | f);
    @(posedge core_clk);
    able <= 1'b0;
    repeat (3) @(posedge core_clk);
    acc(1, AAR_IDX_EXP, 16'h0064 | f);
    for (int k = 0; k < 20 && expQ.size() != 0; k++) @(posedge core_clk);
    if (expQ.size() != 0) ck("pending", 16'h0000, 16'(expQ.size()));
    results();
  end
endmodule : tb_top
